// [logic/call_in_pkg.sv]
// shared types and constants of the call-in sequencer
package call_in_pkg;

	//==================== timing
	localparam longint unsigned CLK_HZ = 20_000_000;
	localparam longint unsigned WAKE_WAIT_S = 30;
	localparam longint unsigned WAKE_WAIT_CYCLES = WAKE_WAIT_S * CLK_HZ;

	//==================== sizes and reset values
	localparam int unsigned FIFO_DEPTH = 4;
	localparam int unsigned UP_WORD_W = 9;
	localparam int unsigned TIME_W = 32;
	localparam int unsigned IDLE_W = 24;
	localparam logic [31:0] DIAL_NUMBER_RESET = 32'h0000_0000;
	localparam logic [31:0] SCHED_TIME_RESET = 32'h0000_0000;

	//==================== card requests and commands
	typedef enum logic [2:0] {
		REQ_NONE = 3'h0,
		REQ_CALL_IN = 3'h1,
		REQ_TERMINATE = 3'h2,
		REQ_GET_SCHED = 3'h3,
		REQ_OTHER = 3'h4
	} card_req_kind_t;

	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_ADDRESSEE = 3'h1,
		CMD_CONN_STATUS = 3'h2,
		CMD_DATA_REQ = 3'h3,
		CMD_CENTER_REPLY = 3'h4,
		CMD_SCHED_REQ = 3'h5
	} card_cmd_t;

	//==================== sequencer states, gray along the call path
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_GET_NUM = 3'b001,
		ST_DIAL = 3'b011,
		ST_SESSION = 3'b010,
		ST_HANGUP = 3'b110,
		ST_WRAP = 3'b111,
		ST_GET_SCHED = 3'b101,
		ST_WAIT_CALL = 3'b100
	} seq_state_t;

	//==================== carriers
	typedef struct packed {
		logic valid;
		card_req_kind_t kind;
	} card_req_t;

	typedef struct packed {
		logic valid;
		card_cmd_t code;
		logic conn_ok;
	} card_cmd_msg_t;

	typedef struct packed {
		logic valid;
		logic ok;
		logic [31:0] data;
	} card_rsp_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic seg_end;
		logic more;
	} up_word_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic eom;
	} link_word_t;

	typedef struct packed {
		logic connected;
		logic failed;
		logic line_up;
	} modem_stat_t;

endpackage

// [logic/word_fifo.sv]
// small synchronous fifo with registered ready and valid
`timescale 1ns/1ns
module word_fifo #(
	parameter int unsigned W = 9,
	parameter int unsigned DEPTH = 4
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [W-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [W-1:0] out_data_out
);
	// depth must be a power of two so the pointers wrap by themselves
	localparam int unsigned AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_data_out = mem[rd_ptr];

	always_comb begin
		next_count = count;
		if (push && !pop)
			next_count = count + 1'b1;
		else if (pop && !push)
			next_count = count - 1'b1;
	end

	always_ff @(posedge core_clk_in) begin
		if (push)
			mem[wr_ptr] <= in_data_in;
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_out <= 1'b0;
			out_valid_out <= 1'b0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= next_count;
			in_ready_out <= next_count < (AW+1)'(DEPTH);
			out_valid_out <= next_count != '0;
		end
	end
endmodule // word_fifo

// [logic/call_in_sequencer.sv]
// call-in sequencer: card requests, modem session, scheduled wake-up
`timescale 1ns/1ns
//==================== behaviour
// Behaviour
// RULE1: schedule request from card reads next call-in
// RULE2: session starts only on card call-in request
// RULE3: fetch center number first, then dial it
// RULE4: report connection result; failure ends session
// RULE5: card termination request makes receiver hang up
// RULE6: after session, read schedule when card asks
// RULE7: relay payload both ways unchanged
// RULE8: payload normally moves with center-reply command
// RULE9: data-request each segment, join, then forward
// RULE10: line drop ends with connection-status command
// RULE11: inactivity or logical error hangs up call
// RULE12: invalid schedule disables scheduled wake-up
// RULE13: read schedule at card insertion with power
// RULE14: compare schedule always; when due, power up
// RULE15: stay able to call while schedule passed
// RULE16: card updates schedule, receiver reads it
// RULE17: no call-in 30 s after wake: reread
// RULE18: lamp lit while call-in in progress
// RULE19: afterwards restore state, drop woken power
// RULE20: further card instructions are carried out
// RULE21: all call-in causes handled the same
// RULE22: card may call in after retry over
// RULE23: inactivity is programmable restartable counter
module call_in_sequencer #(
	parameter longint unsigned WAKE_WAIT = call_in_pkg::WAKE_WAIT_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire call_in_pkg::card_req_t card_req_in,
	input wire call_in_pkg::card_rsp_t card_rsp_in,
	output call_in_pkg::card_cmd_msg_t card_cmd_out,
	input wire call_in_pkg::up_word_t up_word_in,
	output logic up_ready_out,
	output call_in_pkg::link_word_t card_down_out,
	input wire call_in_pkg::link_word_t center_word_in,
	output call_in_pkg::link_word_t modem_tx_out,
	input wire logic modem_tx_ready_in,
	input wire call_in_pkg::modem_stat_t modem_stat_in,
	output logic dial_out,
	output logic [31:0] dial_number_out,
	output logic hangup_out,
	input wire logic [31:0] now_in,
	input wire logic standby_in,
	input wire logic main_power_in,
	input wire logic card_present_in,
	input wire logic sched_nv_in,
	input wire logic [23:0] idle_limit_in,
	output logic lamp_out,
	output logic circuit_power_out
);
	import call_in_pkg::*;

	//==================== declarations
	seq_state_t state;
	logic [TIME_W-1:0] sched_time;
	logic sched_valid;
	logic woke;
	logic served;
	logic init_ok_seen;
	logic init_pend;
	logic data_req_pend;
	logic [31:0] wait_cnt;
	logic [IDLE_W-1:0] idle_cnt;
	logic req_call;
	logic req_term;
	logic req_sched;
	logic rsp_err;
	logic due;
	logic wake;
	logic in_call;
	logic idle_expired;
	logic wait_expired;
	logic issue_reply;
	logic issue_data_req;
	logic wrap_quiet;
	logic fifo_push;
	logic fifo_valid;
	logic fifo_ready;
	logic [UP_WORD_W-1:0] fifo_data;
	logic init_ok;

	function automatic card_cmd_msg_t cmd(card_cmd_t c, logic ok);
		cmd = '{valid: 1'b1, code: c, conn_ok: ok};
	endfunction

	//==================== request decode
	// the cause of a call-in is not distinguished
	assign req_call = card_req_in.valid && card_req_in.kind == REQ_CALL_IN; // RULE21
	assign req_term = card_req_in.valid && card_req_in.kind == REQ_TERMINATE;
	assign req_sched = card_req_in.valid && card_req_in.kind == REQ_GET_SCHED;
	assign rsp_err = card_rsp_in.valid && !card_rsp_in.ok;
	assign due = sched_valid && now_in >= sched_time; // RULE14 RULE12
	assign wake = state == ST_IDLE && due && !served && !req_call &&
		!req_sched && !init_pend;
	assign in_call = state inside {ST_GET_NUM, ST_DIAL, ST_SESSION,
		ST_HANGUP};
	assign idle_expired = idle_cnt >= idle_limit_in; // RULE23
	assign wait_expired = wait_cnt >= 32'(WAKE_WAIT - 1); // RULE17
	assign issue_reply = state == ST_SESSION && center_word_in.valid &&
		center_word_in.eom;
	assign issue_data_req = state == ST_SESSION && data_req_pend &&
		!issue_reply && !req_term && modem_stat_in.line_up && !rsp_err &&
		!idle_expired;
	assign wrap_quiet = state == ST_WRAP && !req_sched && !req_call;
	assign init_ok = card_present_in && (main_power_in || sched_nv_in);

	//==================== sequencer
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
			card_cmd_out <= '0;
			dial_out <= 1'b0;
			hangup_out <= 1'b0;
			dial_number_out <= DIAL_NUMBER_RESET;
		end else begin
			card_cmd_out <= '0;
			dial_out <= 1'b0;
			hangup_out <= 1'b0;
			unique case (state)
			ST_IDLE, ST_WAIT_CALL: begin
				if (req_call) begin
					state <= ST_GET_NUM; // RULE2 RULE15
					card_cmd_out <= cmd(CMD_ADDRESSEE, 1'b0); // RULE3
				end else if (req_sched || init_pend ||
					(state == ST_WAIT_CALL && wait_expired)) begin
					state <= ST_GET_SCHED; // RULE1 RULE13 RULE16 RULE17
					card_cmd_out <= cmd(CMD_SCHED_REQ, 1'b0);
				end else if (wake) begin
					state <= ST_WAIT_CALL; // RULE14
				end
			end
			ST_GET_NUM: begin
				if (card_rsp_in.valid && card_rsp_in.ok) begin
					dial_number_out <= card_rsp_in.data; // RULE3
					dial_out <= 1'b1;
					state <= ST_DIAL;
				end else if (card_rsp_in.valid) begin
					state <= ST_WRAP;
				end
			end
			ST_DIAL: begin
				if (modem_stat_in.connected) begin
					card_cmd_out <= cmd(CMD_CONN_STATUS, 1'b1); // RULE4
					state <= ST_SESSION;
				end else if (modem_stat_in.failed) begin
					card_cmd_out <= cmd(CMD_CONN_STATUS, 1'b0); // RULE4
					state <= ST_WRAP;
				end
			end
			ST_SESSION: begin
				if (req_term) begin
					hangup_out <= 1'b1; // RULE5
					state <= ST_HANGUP;
				end else if (!modem_stat_in.line_up) begin
					card_cmd_out <= cmd(CMD_CONN_STATUS, 1'b0); // RULE10
					state <= ST_WRAP;
				end else if (rsp_err || idle_expired) begin
					hangup_out <= 1'b1; // RULE11
					state <= ST_HANGUP;
				end else if (issue_reply) begin
					card_cmd_out <= cmd(CMD_CENTER_REPLY, 1'b1); // RULE8
				end else if (issue_data_req) begin
					card_cmd_out <= cmd(CMD_DATA_REQ, 1'b1); // RULE9
				end
			end
			ST_HANGUP: begin
				// the modem drops the line after the hang-up pulse
				if (!modem_stat_in.line_up)
					state <= ST_WRAP;
			end
			ST_WRAP: begin
				if (req_sched) begin
					state <= ST_GET_SCHED; // RULE6 RULE20
					card_cmd_out <= cmd(CMD_SCHED_REQ, 1'b0);
				end else if (req_call) begin
					state <= ST_GET_NUM; // RULE20 RULE15
					card_cmd_out <= cmd(CMD_ADDRESSEE, 1'b0);
				end else begin
					state <= ST_IDLE; // RULE19
				end
			end
			ST_GET_SCHED: begin
				if (card_rsp_in.valid)
					state <= ST_IDLE;
			end
			endcase
		end
	end

	//==================== schedule
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			sched_time <= SCHED_TIME_RESET;
			sched_valid <= 1'b0;
		end else if (state == ST_GET_SCHED && card_rsp_in.valid) begin
			sched_time <= card_rsp_in.data; // RULE1
			sched_valid <= card_rsp_in.ok; // RULE12
		end
	end

	// init read is requested on the rise of card-present with main power or kept schedule
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			init_ok_seen <= 1'b0;
			init_pend <= 1'b0;
		end else begin
			init_ok_seen <= init_ok;
			if (init_ok && !init_ok_seen)
				init_pend <= 1'b1; // RULE13
			else if (state == ST_GET_SCHED)
				init_pend <= 1'b0;
		end
	end

	// one wake per schedule; a fresh read re-arms it
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			woke <= 1'b0;
			served <= 1'b0;
		end else begin
			if (wake)
				woke <= 1'b1; // RULE14
			else if (wrap_quiet ||
				(state == ST_GET_SCHED && card_rsp_in.valid))
				woke <= 1'b0; // RULE19
			if (wake)
				served <= 1'b1;
			else if (state == ST_GET_SCHED && card_rsp_in.valid)
				served <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in)
			wait_cnt <= '0;
		else if (state == ST_WAIT_CALL)
			wait_cnt <= wait_cnt + 1'b1; // RULE17
		else
			wait_cnt <= '0;
	end

	//==================== indicators and power
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			lamp_out <= 1'b0;
			circuit_power_out <= 1'b0;
		end else begin
			lamp_out <= in_call; // RULE18
			// awake in normal use; in standby only while woken or busy
			circuit_power_out <= !standby_in || woke || wake || in_call ||
				state != ST_IDLE; // RULE14 RULE19
		end
	end

	//==================== upload path, card to center
	// words offered outside a session are not taken
	assign fifo_push = up_word_in.valid && state == ST_SESSION && up_ready_out;

	word_fifo #(
		.W(UP_WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_up_fifo (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.in_valid_in(up_word_in.valid && state == ST_SESSION),
		.in_ready_out(up_ready_out),
		.in_data_in({up_word_in.data,
			up_word_in.seg_end && !up_word_in.more}), // RULE9
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_ready),
		.out_data_out(fifo_data)
	);

	assign fifo_ready = !modem_tx_out.valid || modem_tx_ready_in;

	// only the final segment carries the end mark: one joined message
	always_ff @(posedge core_clk_in) begin
		if (rst_in)
			data_req_pend <= 1'b0;
		else if (fifo_push && up_word_in.seg_end && up_word_in.more)
			data_req_pend <= 1'b1; // RULE9
		else if (issue_data_req || state != ST_SESSION)
			data_req_pend <= 1'b0;
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in)
			modem_tx_out <= '0;
		else if (fifo_ready)
			modem_tx_out <= '{valid: fifo_valid,
				data: fifo_data[UP_WORD_W-1:1],
				eom: fifo_data[0]}; // RULE7
	end

	//==================== download path, center to card
	always_ff @(posedge core_clk_in) begin
		if (rst_in)
			card_down_out <= '0;
		else if (state == ST_SESSION)
			card_down_out <= center_word_in; // RULE7
		else
			card_down_out <= '0;
	end

	//==================== inactivity
	always_ff @(posedge core_clk_in) begin
		if (rst_in)
			idle_cnt <= '0;
		else if (state != ST_SESSION || fifo_push || center_word_in.valid)
			idle_cnt <= '0; // RULE23
		else if (!idle_expired)
			idle_cnt <= idle_cnt + 1'b1;
	end

	//==================== checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	a_dial_number: assert property ( // RULE3
		state == ST_GET_NUM && card_rsp_in.valid && card_rsp_in.ok |=>
		dial_out && dial_number_out == $past(card_rsp_in.data) &&
		state == ST_DIAL)
		else $error("dial not taken from card number");
	a_call_only_req: assert property ( // RULE2
		state == ST_IDLE && !req_call |=> state != ST_GET_NUM)
		else $error("session began without call-in request");
	a_fail_report: assert property ( // RULE4
		state == ST_DIAL && !modem_stat_in.connected &&
		modem_stat_in.failed |=>
		card_cmd_out.valid && card_cmd_out.code == CMD_CONN_STATUS &&
		!card_cmd_out.conn_ok ##1 state != ST_SESSION)
		else $error("failed dial not reported or session went on");
	a_term_hangup: assert property ( // RULE5
		state == ST_SESSION && req_term |=> hangup_out &&
		state == ST_HANGUP)
		else $error("termination request did not hang up");
	a_drop_notify: assert property ( // RULE10
		state == ST_SESSION && !req_term && !modem_stat_in.line_up |=>
		card_cmd_out.valid && card_cmd_out.code == CMD_CONN_STATUS)
		else $error("line drop not notified to card");
	a_idle_hangup: assert property ( // RULE11
		state == ST_SESSION && modem_stat_in.line_up && !req_term &&
		(rsp_err || idle_expired) |=> hangup_out)
		else $error("inactivity or error did not hang up");
	a_sched_invalid: assert property ( // RULE12
		state == ST_GET_SCHED && card_rsp_in.valid &&
		!card_rsp_in.ok |=> !sched_valid ##1 state != ST_WAIT_CALL)
		else $error("invalid schedule still armed");
	a_lamp_session: assert property ( // RULE18
		state == ST_SESSION |=> lamp_out)
		else $error("lamp dark during call-in");
	a_relay_clean: assert property ( // RULE7
		state == ST_SESSION && center_word_in.valid |=>
		card_down_out.valid &&
		card_down_out.data == $past(center_word_in.data))
		else $error("center data altered on the way to card");
	a_wake_reread: assert property ( // RULE17
		state == ST_WAIT_CALL && wait_expired && !req_call |=>
		state == ST_GET_SCHED && card_cmd_out.valid &&
		card_cmd_out.code == CMD_SCHED_REQ)
		else $error("no schedule reread after wake timeout");
	a_wake_power: assert property ( // RULE14
		wake |=> circuit_power_out && state == ST_WAIT_CALL)
		else $error("due schedule did not power up");
endmodule // call_in_sequencer

// [verif/card_modem_model.sv]
// behavioural smart card and modem line facing the call-in sequencer
`timescale 1ns/1ns
module card_modem_model (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire call_in_pkg::card_cmd_msg_t card_cmd_in,
	input wire logic dial_in,
	input wire logic hangup_in,
	input wire logic fail_dial_in,
	input wire logic drop_in,
	input wire logic rsp_ok_in,
	input wire logic [31:0] rsp_data_in,
	output call_in_pkg::card_rsp_t card_rsp_out,
	output call_in_pkg::modem_stat_t modem_stat_out
);
	import call_in_pkg::*;
	//==================== card answers
	// idle data is the inverse so a stale value is never mistaken for news
	always_ff @(posedge core_clk_in) begin
		card_rsp_out <= '{1'b0, 1'b0, ~rsp_data_in};
		if (!rst_in && card_cmd_in.valid === 1'b1 &&
			card_cmd_in.code inside {CMD_ADDRESSEE, CMD_SCHED_REQ}) begin
			card_rsp_out <= '{1'b1, rsp_ok_in, rsp_data_in};
		end
	end
	//==================== modem line: connect pulse, line level
	always_ff @(posedge core_clk_in) begin
		modem_stat_out.connected <= dial_in && !fail_dial_in;
		modem_stat_out.failed <= dial_in && fail_dial_in;
		if (rst_in || hangup_in || drop_in) begin
			modem_stat_out.line_up <= 1'b0;
		end else if (dial_in && !fail_dial_in) begin
			modem_stat_out.line_up <= 1'b1;
		end
	end
endmodule // card_modem_model

// [verif/tb.sv]
// self-checking bench of the call-in sequencer
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
	n_fail++; $display("Error at %0t: value mismatch", $time); end end
module tb;
	import call_in_pkg::*;
	//==================== signals
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	card_req_t card_req_in = '0;
	card_rsp_t card_rsp_in;
	card_cmd_msg_t card_cmd_out;
	up_word_t up_word_in = '0;
	logic up_ready_out;
	link_word_t card_down_out, modem_tx_out;
	link_word_t center_word_in = '0;
	logic modem_tx_ready_in = 1'b0;
	modem_stat_t modem_stat_in;
	logic dial_out, hangup_out, lamp_out, circuit_power_out;
	logic [31:0] dial_number_out;
	logic [31:0] now_in = 32'h0000_0064;
	logic standby_in = 1'b1;
	logic card_present_in = 1'b0;
	logic main_power_in = 1'b1;
	logic sched_nv_in = 1'b0;
	logic [23:0] idle_limit_in = 24'h0003e8;
	logic fail_dial = 1'b0, drop = 1'b0, rsp_ok = 1'b0;
	logic [31:0] rsp_data = 32'h0000_0050;
	int n_fail = 0, n_compared = 0, n_dreq = 0, waited = 0, n_sreq = 0;
	logic [8:0] sent[$];

	always #25 core_clk_in = ~core_clk_in;

	call_in_sequencer #(.WAKE_WAIT(50)) dut (.core_clk_in, .rst_in,
		.card_req_in, .card_rsp_in, .card_cmd_out, .up_word_in,
		.up_ready_out, .card_down_out, .center_word_in, .modem_tx_out,
		.modem_tx_ready_in, .modem_stat_in, .dial_out, .dial_number_out,
		.hangup_out, .now_in, .standby_in, .main_power_in,
		.card_present_in, .sched_nv_in, .idle_limit_in, .lamp_out,
		.circuit_power_out);
	card_modem_model far_side (.core_clk_in, .rst_in,
		.card_cmd_in(card_cmd_out), .dial_in(dial_out),
		.hangup_in(hangup_out), .fail_dial_in(fail_dial), .drop_in(drop),
		.rsp_ok_in(rsp_ok), .rsp_data_in(rsp_data),
		.card_rsp_out(card_rsp_in), .modem_stat_out(modem_stat_in));

	//==================== observers
	always @(posedge core_clk_in) begin
		if (modem_tx_out.valid === 1'b1 && modem_tx_ready_in)
			sent.push_back({modem_tx_out.data, modem_tx_out.eom});
		if (card_cmd_out.valid === 1'b1 && card_cmd_out.code === CMD_DATA_REQ)
			n_dreq++;
		if (card_cmd_out.valid === 1'b1 && card_cmd_out.code === CMD_SCHED_REQ)
			n_sreq++;
	end

	//==================== shared tasks
	task automatic complete_run();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic hung();
		n_fail++;
		$display("Error at %0t: wait ran out", $time);
		complete_run();
	endtask

	// k: 0 command c, 1 dial, 2 hang-up, 3 circuit power
	task automatic await(input int k, input card_cmd_t c);
		bit hit;
		hit = 0;
		for (waited = 0; waited < 300 && !hit; waited++) begin
			@(negedge core_clk_in);
			case (k)
				0: hit = card_cmd_out.valid === 1'b1 && card_cmd_out.code === c;
				1: hit = dial_out === 1'b1;
				2: hit = hangup_out === 1'b1;
				default: hit = circuit_power_out === 1'b1;
			endcase
		end
		if (!hit) hung();
	endtask

	task automatic req(input card_req_kind_t k);
		@(posedge core_clk_in);
		card_req_in <= '{1'b1, k};
		@(posedge core_clk_in);
		card_req_in <= '0;
	endtask

	// entered just after an edge; leaves valid up for the caller to drop
	task automatic push(input logic [7:0] d, input logic se, input logic mo);
		int i;
		up_word_in <= '{1'b1, d, se, mo};
		for (i = 0; i < 100; i++) begin
			@(posedge core_clk_in);
			if (up_ready_out === 1'b1) break;
		end
		if (i == 100) hung();
	endtask

	task automatic call_up(output logic ok);
		req(REQ_CALL_IN);
		await(0, CMD_ADDRESSEE);
		await(1, CMD_NONE);
		`CHK(dial_number_out, rsp_data)
		`CHK(lamp_out, 1'b1)
		await(0, CMD_CONN_STATUS);
		ok = card_cmd_out.conn_ok;
	endtask

	//==================== scenarios
	task automatic sc_wake();
		@(posedge core_clk_in);
		main_power_in <= 1'b0;
		card_present_in <= 1'b1;
		// without main power or kept schedule no init read is made
		repeat (10) @(negedge core_clk_in);
		`CHK(n_sreq, 0)
		@(posedge core_clk_in);
		sched_nv_in <= 1'b1;
		await(0, CMD_SCHED_REQ);
		repeat (20) @(negedge core_clk_in);
		`CHK(circuit_power_out, 1'b0)
		@(posedge core_clk_in);
		rsp_ok <= 1'b1;
		req(REQ_GET_SCHED);
		await(0, CMD_SCHED_REQ);
		await(3, CMD_NONE);
		@(posedge core_clk_in);
		rsp_data <= 32'hffff_ffff;
		await(0, CMD_SCHED_REQ);
		`CHK(waited >= 48 && waited <= 53, 1'b1)
		// woken from standby: power drops once the reread is done
		repeat (10) @(negedge core_clk_in);
		`CHK(circuit_power_out, 1'b0)
	endtask

	task automatic sc_session();
		logic ok;
		int i;
		call_up(ok);
		`CHK(ok, 1'b1)
		@(posedge core_clk_in);
		center_word_in <= '{1'b1, 8'ha5, 1'b1};
		@(posedge core_clk_in);
		center_word_in <= '{1'b0, 8'h5a, 1'b0};
		@(negedge core_clk_in);
		`CHK(card_down_out, link_word_t'{1'b1, 8'ha5, 1'b1})
		`CHK(card_cmd_out.code, CMD_CENTER_REPLY)
		@(posedge core_clk_in);
		// modem stalls so the fifo fills and must refuse
		fork
			for (i = 0; i < 6; i++) push(8'h30 + i[7:0], i == 2 || i == 5, i == 2);
			begin
				repeat (30) @(posedge core_clk_in);
				`CHK(up_ready_out, 1'b0)
				modem_tx_ready_in <= 1'b1;
			end
		join
		up_word_in <= '{1'b0, 8'hcf, 1'b0, 1'b0};
		repeat (10) @(posedge core_clk_in);
		`CHK(sent.size(), 6)
		for (i = 0; i < sent.size(); i++)
			`CHK(sent[i], {8'h30 + i[7:0], i == 5})
		`CHK(n_dreq, 1)
		req(REQ_TERMINATE);
		await(2, CMD_NONE);
		repeat (4) @(negedge core_clk_in);
		`CHK(lamp_out, 1'b0)
		req(REQ_GET_SCHED);
		await(0, CMD_SCHED_REQ);
	endtask

	task automatic sc_faults();
		logic ok;
		@(posedge core_clk_in);
		fail_dial <= 1'b1;
		req(REQ_OTHER);
		call_up(ok);
		`CHK(ok, 1'b0)
		repeat (4) @(negedge core_clk_in);
		`CHK(lamp_out, 1'b0)
		@(posedge core_clk_in);
		fail_dial <= 1'b0;
		call_up(ok);
		@(posedge core_clk_in);
		drop <= 1'b1;
		await(0, CMD_CONN_STATUS);
		`CHK(card_cmd_out.conn_ok, 1'b0)
		@(posedge core_clk_in);
		drop <= 1'b0;
		idle_limit_in <= 24'h000014;
		call_up(ok);
		await(2, CMD_NONE);
		`CHK(waited >= 16 && waited <= 24, 1'b1)
	endtask

	//==================== main sequence
	initial begin
		repeat (16) @(posedge core_clk_in);
		@(negedge core_clk_in);
		`CHK(card_cmd_out.valid, 1'b0)
		`CHK(circuit_power_out, 1'b0)
		@(posedge core_clk_in);
		rst_in <= 1'b0;
		sc_wake();
		@(posedge core_clk_in);
		standby_in <= 1'b0;
		sc_session();
		sc_faults();
		complete_run();
	end
endmodule // tb
